// file: erb_pkg.sv
// constants, field layouts and helper functions for the embedded ram block
package erb_pkg;

  localparam int ERB_WIDTH = 36;
  localparam int ERB_DEPTH = 256;
  localparam int ERB_AW = 13;
  localparam int ERB_CNT_W = 9;
  localparam int ERB_SRM_W = 9;

  // ============================================================
  // operating modes
  localparam logic [2:0] ERB_MODE_SP = 3'h0;
  localparam logic [2:0] ERB_MODE_SDP = 3'h1;
  localparam logic [2:0] ERB_MODE_TDP = 3'h2;
  localparam logic [2:0] ERB_MODE_ROM = 3'h3;
  localparam logic [2:0] ERB_MODE_SR = 3'h4;
  localparam logic [2:0] ERB_MODE_FIFO = 3'h5;

  // ============================================================
  // port shapes: 8192x1 .. 256x32 then 1024x9, 512x18, 256x36
  localparam logic [3:0] ERB_SHAPE_X16 = 4'h4;
  localparam logic [3:0] ERB_SHAPE_X32 = 4'h5;
  localparam logic [3:0] ERB_SHAPE_NINE = 4'h6;
  localparam logic [3:0] ERB_SHAPE_X18 = 4'h7;
  localparam logic [3:0] ERB_SHAPE_X36 = 4'h8;

  // ============================================================
  // apb register map and reset values
  localparam logic [11:0] ERB_CTRL_OFS = 12'h000;
  localparam logic [11:0] ERB_SRCFG_OFS = 12'h004;
  localparam logic [11:0] ERB_STAT_OFS = 12'h008;
  localparam logic [31:0] ERB_CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] ERB_SRCFG_RST = 32'h0000_8041;

  localparam logic [35:0] ERB_DC_FILL = 36'hF_FFFF_FFFF;
  localparam logic [35:0] ERB_ZERO = 36'h0_0000_0000;
  localparam logic [13:0] ERB_SR_MAX_BITS = 14'h2400;
  localparam logic [11:0] ERB_SR_MAX_W = 12'h024;

  typedef struct packed {
    logic [15:0] rsvd;
    logic [3:0] shape_b;
    logic [3:0] shape_a;
    logic rsvd2;
    logic mp_old;
    logic sp_old;
    logic oreg_b;
    logic oreg_a;
    logic [2:0] mode;
  } erb_ctrl_t;

  typedef struct packed {
    logic [10:0] rsvd;
    logic [5:0] taps;
    logic [8:0] tap_len;
    logic [5:0] width;
  } erb_srcfg_t;

  typedef struct packed {
    logic [19:0] rsvd;
    logic [ERB_CNT_W-1:0] count;
    logic full;
    logic empty;
    logic cfg_err;
  } erb_stat_t;

  typedef struct packed {
    logic we;
    logic re;
    logic [3:0] be;
    logic [ERB_AW-1:0] addr;
    logic [ERB_WIDTH-1:0] din;
  } erb_port_t;

  function automatic logic [5:0] erb_shape_width(input logic [3:0] s);
    case (s)
      4'h0: erb_shape_width = 6'h01;
      4'h1: erb_shape_width = 6'h02;
      4'h2: erb_shape_width = 6'h04;
      4'h3: erb_shape_width = 6'h08;
      4'h4: erb_shape_width = 6'h10;
      4'h5: erb_shape_width = 6'h20;
      4'h6: erb_shape_width = 6'h09;
      4'h7: erb_shape_width = 6'h12;
      default: erb_shape_width = 6'h24;
    endcase
  endfunction

  function automatic logic [35:0] erb_mask(input logic [5:0] w);
    erb_mask = (36'h0_0000_0001 << w) - 36'h0_0000_0001;
  endfunction

  // keeps old bytes where the enable is low; nine-bit bytes for x18/x36
  function automatic logic [35:0] erb_merge(input logic [35:0] old_w,
      input logic [35:0] new_w, input logic [3:0] be, input logic nine);
    logic [35:0] r;
    r = new_w;
    for (int k = 0; k < 4; k++) begin
      if (!be[k]) begin
        if (nine) r[k*9 +: 9] = old_w[k*9 +: 9];
        else r[k*8 +: 8] = old_w[k*8 +: 8];
      end
    end
    erb_merge = r;
  endfunction

endpackage

// file: erb_core.sv
// embedded ram block with apb configuration and six operating modes
//
// Design decisions made here: the APB register port and the register offsets.
`timescale 1ns/10ps
`default_nettype none

module erb_core
  import erb_pkg::*;
#(
  parameter int DEPTH = ERB_DEPTH
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic clken,
  input wire logic aclr_a,
  input wire logic aclr_b,
  input wire erb_port_t port_a,
  input wire erb_port_t port_b,
  output logic [ERB_WIDTH-1:0] q_a,
  output logic [ERB_WIDTH-1:0] q_b,
  output logic fifo_empty,
  output logic fifo_full,
  output logic cfg_err
);

  localparam int IW = $clog2(DEPTH);

  generate
    if (DEPTH < 2 || DEPTH > ERB_DEPTH || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
      $error("erb_core: DEPTH must be a power of two up to 256");
    end
  endgenerate

  // ============================================================
  // apb slave
  erb_ctrl_t ctrl_reg;
  erb_srcfg_t srcfg_reg;
  erb_stat_t stat_w;
  logic [31:0] prdata_reg;
  logic pready_reg;
  logic pslverr_reg;

  wire logic setup = psel & ~penable;
  wire logic wr_go = psel & penable & pwrite & pready_reg;
  wire logic hit_ctrl = (paddr == ERB_CTRL_OFS);
  wire logic hit_sr = (paddr == ERB_SRCFG_OFS);
  wire logic hit_st = (paddr == ERB_STAT_OFS);
  wire logic mapped = hit_ctrl | hit_sr | hit_st;
  wire logic [31:0] rd_word = hit_ctrl ? ctrl_reg :
                              hit_sr ? srcfg_reg :
                              hit_st ? stat_w : 32'h0000_0000;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h0000_0000;
    end else begin
      pready_reg <= setup;
      pslverr_reg <= setup & ~mapped;
      prdata_reg <= setup ? rd_word : prdata_reg;
    end
  end

  // status is read-only; writes to it are dropped silently
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= ERB_CTRL_RST;
      srcfg_reg <= ERB_SRCFG_RST;
    end else begin
      if (wr_go & hit_ctrl) ctrl_reg <= pwdata;
      if (wr_go & hit_sr) srcfg_reg <= pwdata;
    end
  end

  // ============================================================
  // mode decode and configuration check
  wire logic m_sp = (ctrl_reg.mode == ERB_MODE_SP);
  wire logic m_sdp = (ctrl_reg.mode == ERB_MODE_SDP);
  wire logic m_tdp = (ctrl_reg.mode == ERB_MODE_TDP);
  wire logic m_rom = (ctrl_reg.mode == ERB_MODE_ROM);
  wire logic m_sr = (ctrl_reg.mode == ERB_MODE_SR);
  wire logic m_fifo = (ctrl_reg.mode == ERB_MODE_FIFO);
  wire logic [3:0] sh_a = ctrl_reg.shape_a;
  wire logic [3:0] sh_b = ctrl_reg.shape_b;
  wire logic nine_a = (sh_a >= ERB_SHAPE_NINE);
  wire logic nine_b = (sh_b >= ERB_SHAPE_NINE);
  wire logic sh_ok = (sh_a <= ERB_SHAPE_X36) & (sh_b <= ERB_SHAPE_X36);
  wire logic fam_eq = (nine_a == nine_b);
  wire logic tdp_wide = (sh_a == ERB_SHAPE_X32) | (sh_a == ERB_SHAPE_X36) |
                        (sh_b == ERB_SHAPE_X32) | (sh_b == ERB_SHAPE_X36);
  wire logic [11:0] sr_wn = srcfg_reg.width * srcfg_reg.taps;
  wire logic [20:0] sr_wmn = sr_wn * srcfg_reg.tap_len;
  wire logic sr_ok = (sr_wn <= ERB_SR_MAX_W) &
                     (sr_wmn <= 21'(ERB_SR_MAX_BITS)) &
                     (srcfg_reg.width != 6'h00) & (srcfg_reg.taps != 6'h00) &
                     (srcfg_reg.tap_len != 9'h000) &
                     (srcfg_reg.tap_len <= 9'(DEPTH));
  wire logic cfg_ok = sh_ok & ((m_sp | m_rom) |
                      (m_sdp & fam_eq) |
                      (m_tdp & fam_eq & ~tdp_wide) |
                      (m_fifo & fam_eq) | (m_sr & sr_ok));
  // clock enable low freezes every memory-side operation
  wire logic go = clken & cfg_ok;

  // ============================================================
  // memory array and port paths
  logic [ERB_WIDTH-1:0] mem [DEPTH];

  // rom image: fixed pattern, stands in for a loaded initialization image
  initial begin
    for (int i = 0; i < DEPTH; i++) begin
      mem[i] = ERB_WIDTH'(i * 3 + 1);
    end
  end

  wire logic [35:0] mask_a = erb_mask(erb_shape_width(sh_a));
  wire logic [35:0] mask_b = erb_mask(erb_shape_width(sh_b));
  wire logic be_on_a = (sh_a == ERB_SHAPE_X16) | (sh_a == ERB_SHAPE_X32) |
                       (sh_a == ERB_SHAPE_X18) | (sh_a == ERB_SHAPE_X36);
  wire logic be_on_b = (sh_b == ERB_SHAPE_X16) | (sh_b == ERB_SHAPE_X32) |
                       (sh_b == ERB_SHAPE_X18) | (sh_b == ERB_SHAPE_X36);
  wire logic [3:0] be_a = be_on_a ? port_a.be : 4'hF;
  wire logic [3:0] be_b = be_on_b ? port_b.be : 4'hF;
  wire logic [IW-1:0] a_idx = port_a.addr[IW-1:0];
  wire logic [IW-1:0] b_idx = port_b.addr[IW-1:0];
  wire logic same = (a_idx == b_idx);
  wire logic [35:0] old_a = mem[a_idx];
  wire logic [35:0] old_b = mem[b_idx];
  wire logic [35:0] wdat_a = erb_merge(old_a, port_a.din & mask_a, be_a,
                                       nine_a);
  wire logic [35:0] wdat_b = erb_merge(old_b, port_b.din & mask_b, be_b,
                                       nine_b);

  // single port: a write takes the cycle, read enable only picks rdw view
  wire logic wr_a = go & port_a.we & (m_sp | m_sdp | m_tdp);
  wire logic wr_b = go & port_b.we & m_tdp;
  wire logic rd_a = go & port_a.re & (m_sp | m_tdp | m_rom);
  wire logic rd_b = go & port_b.re & (m_sdp | m_tdp);
  // no arbitration: a double write lands as an undefined fill word
  wire logic collide = wr_a & wr_b & same;

  // same-port view: new data flows through unless sp_old is set, masked bytes show old
  wire logic [35:0] val_a = (wr_a & ~ctrl_reg.sp_old) ? wdat_a :
                            (wr_b & same & ~ctrl_reg.mp_old) ? ERB_DC_FILL :
                            old_a;
  wire logic [35:0] val_b = (wr_b & ~ctrl_reg.sp_old) ? wdat_b :
                            (wr_a & same & ~ctrl_reg.mp_old) ? ERB_DC_FILL :
                            old_b;

  // ============================================================
  // shift register: word at pointer holds all taps, lane 0 newest
  logic [ERB_SRM_W-1:0] sr_ptr_reg;
  wire logic sr_shift = go & m_sr & port_a.we;
  wire logic [35:0] sr_wmask = erb_mask(srcfg_reg.width);
  wire logic [35:0] sr_nmask = erb_mask(sr_wn[5:0]);
  wire logic [35:0] sr_old = mem[sr_ptr_reg[IW-1:0]] & sr_nmask;
  wire logic [35:0] sr_new = ((sr_old << srcfg_reg.width) |
                              (port_a.din & sr_wmask)) & sr_nmask;
  wire logic [11:0] sr_top = sr_wn - 12'(srcfg_reg.width);
  wire logic [35:0] sr_out = (sr_old >> sr_top) & sr_wmask;
  wire logic sr_wrap = (sr_ptr_reg == srcfg_reg.tap_len - 9'h001);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) sr_ptr_reg <= '0;
    else if (sr_shift) sr_ptr_reg <= sr_wrap ? '0 : sr_ptr_reg + 9'h001;
    else if (!m_sr) sr_ptr_reg <= '0;
  end

  // ============================================================
  // fifo: single clock, push on port a, pop on port b
  logic [IW:0] wptr_reg;
  logic [IW:0] rptr_reg;
  logic fifo_empty_reg;
  logic fifo_full_reg;
  wire logic [IW:0] fcnt = wptr_reg - rptr_reg;
  // empty pop is dropped, so a push into an empty fifo never races a pop
  wire logic push = go & m_fifo & port_a.we & ~fifo_full_reg;
  wire logic pop = go & m_fifo & port_b.re & ~fifo_empty_reg;
  wire logic [IW:0] wptr_next = wptr_reg + (IW+1)'(push);
  wire logic [IW:0] rptr_next = rptr_reg + (IW+1)'(pop);
  wire logic [IW:0] fcnt_next = wptr_next - rptr_next;
  wire logic [35:0] fifo_out = mem[rptr_reg[IW-1:0]] & mask_b;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wptr_reg <= '0;
      rptr_reg <= '0;
      fifo_empty_reg <= 1'b1;
      fifo_full_reg <= 1'b0;
    end else begin
      wptr_reg <= m_fifo ? wptr_next : '0;
      rptr_reg <= m_fifo ? rptr_next : '0;
      fifo_empty_reg <= ~m_fifo | (fcnt_next == '0);
      fifo_full_reg <= m_fifo & (fcnt_next == (IW+1)'(DEPTH));
    end
  end

  // ============================================================
  // memory write ports; the array itself has no clear
  wire logic w0_en = wr_a | sr_shift | push;
  wire logic [IW-1:0] w0_idx = m_sr ? sr_ptr_reg[IW-1:0] :
                               m_fifo ? wptr_reg[IW-1:0] : a_idx;
  wire logic [35:0] w0_dat = m_sr ? sr_new :
                             m_fifo ? (port_a.din & mask_a) :
                             collide ? ERB_DC_FILL : wdat_a;
  wire logic w1_en = wr_b & ~collide;

  // plain always: the rom image preload also writes this array
  always @(posedge pclk) begin
    if (w0_en) mem[w0_idx] <= w0_dat;
    if (w1_en) mem[b_idx] <= wdat_b;
  end

  // ============================================================
  // read latches and output registers, the only state that aclr_a and aclr_b clear
  logic [35:0] lat_a_reg;
  logic [35:0] lat_b_reg;
  logic [35:0] q_a_reg;
  logic [35:0] q_b_reg;
  logic cfg_err_reg;
  wire logic clr_a_n = presetn & ~aclr_a;
  wire logic clr_b_n = presetn & ~aclr_b;
  wire logic load_a = rd_a | sr_shift;
  wire logic load_b = rd_b | pop | sr_shift;
  // latch holds through cycles without read enable or a shift-register shift
  wire logic [35:0] lat_a_next = ~load_a ? lat_a_reg :
                                 m_sr ? sr_old : (val_a & mask_a);
  wire logic [35:0] lat_b_next = ~load_b ? lat_b_reg :
                                 m_sr ? sr_out :
                                 m_fifo ? fifo_out : (val_b & mask_b);
  // bypass takes the latch value straight; registered adds one edge
  wire logic [35:0] q_a_next = ~clken ? q_a_reg :
                               ctrl_reg.oreg_a ? lat_a_reg : lat_a_next;
  wire logic [35:0] q_b_next = ~clken ? q_b_reg :
                               ctrl_reg.oreg_b ? lat_b_reg : lat_b_next;

  always_ff @(posedge pclk or negedge clr_a_n) begin
    if (!clr_a_n) begin
      lat_a_reg <= ERB_ZERO;
      q_a_reg <= ERB_ZERO;
    end else begin
      lat_a_reg <= lat_a_next;
      q_a_reg <= q_a_next;
    end
  end

  always_ff @(posedge pclk or negedge clr_b_n) begin
    if (!clr_b_n) begin
      lat_b_reg <= ERB_ZERO;
      q_b_reg <= ERB_ZERO;
    end else begin
      lat_b_reg <= lat_b_next;
      q_b_reg <= q_b_next;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) cfg_err_reg <= 1'b0;
    else cfg_err_reg <= ~cfg_ok;
  end

  assign stat_w = '{rsvd: '0, count: ERB_CNT_W'(fcnt), full: fifo_full_reg,
                    empty: fifo_empty_reg, cfg_err: cfg_err_reg};
  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign q_a = q_a_reg;
  assign q_b = q_b_reg;
  assign fifo_empty = fifo_empty_reg;
  assign fifo_full = fifo_full_reg;
  assign cfg_err = cfg_err_reg;

  // ============================================================
  // assertions
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  out_clear_a: assert property (aclr_a |-> q_a_reg == ERB_ZERO)
    else $error("q_a not cleared under aclr_a");
  latch_clear_a: assert property (aclr_b && !ctrl_reg.oreg_b |->
      lat_b_reg == ERB_ZERO && q_b_reg == ERB_ZERO)
    else $error("bypassed q_b not cleared");
  hold_noread_a: assert property (m_sp && go && port_a.we && !port_a.re &&
      !ctrl_reg.oreg_a && !aclr_a ##1 !aclr_a |-> $stable(q_a_reg))
    else $error("q_a moved on write without read");
  oreg_delay_a: assert property (rd_a && ctrl_reg.oreg_a && !aclr_a
      ##1 clken && !aclr_a && $stable(ctrl_reg) ##1 !aclr_a
      |-> q_a_reg == $past(val_a & mask_a, 2))
    else $error("registered read not two edges late");
  sp_newdata_a: assert property (m_sp && wr_a && port_a.re &&
      !ctrl_reg.sp_old && !ctrl_reg.oreg_a ##1 !aclr_a
      |-> q_a_reg == $past(wdat_a & mask_a))
    else $error("new-data read during write wrong");
  sp_olddata_a: assert property (m_sp && wr_a && port_a.re &&
      ctrl_reg.sp_old && !ctrl_reg.oreg_a ##1 !aclr_a
      |-> q_a_reg == $past(old_a & mask_a))
    else $error("old-data read during write wrong");
  dbl_write_a: assert property (collide |=>
      mem[$past(a_idx)] == ERB_DC_FILL)
    else $error("double write not undefined fill");
  rom_nowrite_a: assert property (m_rom && port_a.we |=>
      mem[$past(a_idx)] == $past(old_a))
    else $error("rom contents changed");
  clken_hold_a: assert property (!clken |=> $stable(wptr_reg) &&
      $stable(rptr_reg) && $stable(sr_ptr_reg))
    else $error("operation with clock enable low");
  byte_keep_a: assert property (wr_a && !collide && be_on_a && !nine_a &&
      !port_a.be[0] |=> mem[$past(a_idx)][7:0] == $past(old_a[7:0]))
    else $error("masked byte overwritten");
  sr_limit_a: assert property (m_sr && sr_wn > ERB_SR_MAX_W |=>
      cfg_err_reg)
    else $error("oversize shift register accepted");
  tdp_shape_a: assert property (m_tdp && tdp_wide |-> !go)
    else $error("wide true dual port shape accepted");
  sdp_write_a: assert property (m_sdp && wr_a && rd_b && !same |=>
      mem[$past(a_idx)] == $past(wdat_a))
    else $error("simple dual port write lost");
  read_hold_a: assert property (!load_b && !aclr_b ##1 !aclr_b |->
      $stable(lat_b_reg))
    else $error("port b latch moved without read");
  fifo_push_a: assert property (push |=>
      mem[$past(wptr_reg[IW-1:0])] == $past(port_a.din & mask_a))
    else $error("fifo push not stored");
  // a pop on an empty fifo must leave the read side alone
  fifo_hold_a: assert property (m_fifo && fifo_empty_reg |=>
      $stable(rptr_reg))
    else $error("read pointer moved while empty");
  full_count_a: assert property (fifo_full_reg |->
      fcnt == (IW+1)'(DEPTH) && !fifo_empty_reg)
    else $error("full flag without full count");

  cov_sp_rdw: cover property (m_sp && wr_a && port_a.re);
  cov_collide: cover property (collide);
  cov_fifo_full: cover property (fifo_full_reg);
  cov_sr_wrap: cover property (sr_shift && sr_wrap);
  cov_sdp_rdw: cover property (m_sdp && wr_a && rd_b && same);

endmodule

`default_nettype wire

// file: erb_user.sv
// user-side partner model driving both memory ports
`timescale 1ns/10ps
`default_nettype none

module erb_user
  import erb_pkg::*;
(
  input wire logic pclk,
  input wire logic fifo_empty,
  output var erb_port_t port_a,
  output var erb_port_t port_b,
  output logic clken,
  output logic aclr_a,
  output logic aclr_b
);
  // ============================================================
  // released lines flip, so a stale value never passes for data
  function automatic erb_port_t idle(input erb_port_t p);
    idle = p;
    idle.we = 1'b0;
    idle.re = 1'b0;
    idle.din = ~p.din;
    idle.addr = ~p.addr;
  endfunction

  initial begin
    port_a = '0;
    port_b = '0;
    clken = 1'b1;
    aclr_a = 1'b0;
    aclr_b = 1'b0;
  end

  // ============================================================
  // one op cycle then idle; fl[0] allows a clash, fl[1] fifo use
  task automatic op(input erb_port_t a, input erb_port_t b,
      input logic [1:0] fl);
    erb_port_t c;
    c = b;
    if (!fl[0] && a.we && b.we && a.addr == b.addr) c.we = 1'b0;
    if (fl[1] && fifo_empty && a.we && b.re) c.re = 1'b0;
    @(posedge pclk);
    port_a <= a;
    port_b <= c;
    @(posedge pclk);
    port_a <= idle(a);
    port_b <= idle(c);
    #1;
  endtask

  // clear only between ops, never during a read
  task automatic clr(input logic sel);
    if (sel) aclr_b = 1'b1;
    else aclr_a = 1'b1;
    #1;
  endtask

  task automatic unclr;
    @(posedge pclk);
    aclr_a <= 1'b0;
    aclr_b <= 1'b0;
    #1;
  endtask

  task automatic set_ce(input logic v);
    @(posedge pclk);
    clken <= v;
  endtask
endmodule

`default_nettype wire

// file: erb_core_tb.sv
// self-checking bench for the embedded ram block
`timescale 1ns/10ps
`default_nettype none

module erb_core_tb
  import erb_pkg::*;
;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdv;
  erb_port_t port_a, port_b, nop;
  logic clken, aclr_a, aclr_b, fifo_empty, fifo_full, cfg_err;
  logic [35:0] q_a, q_b, d, e, mem [0:255], fq[$];
  logic [7:0] a, y;
  logic [3:0] be;
  int failures, tests_run;
  localparam logic [3:0] F = 4'hF;
  localparam logic [35:0] M16 = 36'h0_0000_FFFF;

  erb_core erb_core_inst (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .clken, .aclr_a,
    .aclr_b, .port_a, .port_b, .q_a, .q_b, .fifo_empty, .fifo_full,
    .cfg_err);
  erb_user erb_user_inst (.pclk, .fifo_empty, .port_a, .port_b,
    .clken, .aclr_a, .aclr_b);

  // ============================================================
  // shared tasks
  function automatic erb_port_t pt(input logic w, input logic r,
      input logic [3:0] b, input logic [7:0] ad, input logic [35:0] dd);
    pt = {w, r, b, 5'h00, ad, dd};
  endfunction

  function automatic logic [35:0] mrg(input logic [35:0] o,
      input logic [35:0] n, input logic [3:0] b);
    mrg = o;
    for (int k = 0; k < 4; k++) begin
      if (b[k]) mrg[k*8 +: 8] = n[k*8 +: 8];
    end
  endfunction

  task automatic chk(input logic [35:0] s, input logic [35:0] x);
    tests_run++;
    if (s !== x) begin
      failures++;
      $display("wrong value at %0t seen %h expected %h", $time, s, x);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] ad,
      input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= ad;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rdv = pslverr ? 32'hFFFF_FFFF : prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // set mode, flags and shapes, then check the legality flag
  task automatic cf(input logic [2:0] md, input logic [3:0] f,
      input logic [3:0] sa, input logic [3:0] sb, input logic x);
    apb(1'b1, ERB_CTRL_OFS, {16'h0, sb, sa, 1'b0, f, md});
    apb(1'b0, ERB_STAT_OFS, 32'h0);
    chk(36'(rdv[0]), 36'(x));
    chk(36'(cfg_err), 36'(x));
  endtask

  task automatic report_and_stop;
    $display("tests_run %0d failures %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  initial begin
    #400000;
    failures++;
    report_and_stop();
  end

  // ============================================================
  // main sequence
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    nop = '0;
    for (int i = 0; i < 256; i++) mem[i] = 36'(i * 3 + 1);
    void'($urandom(61));
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, ERB_CTRL_OFS, 32'h0);
    chk(36'(rdv), 36'(ERB_CTRL_RST));
    apb(1'b0, ERB_SRCFG_OFS, 32'h0);
    chk(36'(rdv), 36'(ERB_SRCFG_RST));
    apb(1'b0, 12'h00C, 32'h0);
    chk(36'(rdv), 36'h0_FFFF_FFFF);
    apb(1'b1, ERB_STAT_OFS, 32'hFFFF_FFFF);
    apb(1'b0, ERB_STAT_OFS, 32'h0);
    chk(36'(rdv), 36'h2);
    $display("register test finished");
    cf(ERB_MODE_SP, 4'h0, 4'h5, 4'h5, 1'b0);
    for (int i = 0; i < 6; i++) begin
      a = 8'($urandom);
      d = 36'($urandom);
      be = 4'($urandom);
      mem[a] = mrg(mem[a], d, be);
      erb_user_inst.op(pt(1'b1, 1'b1, be, a, d), nop, 2'b00);
      chk(q_a, mem[a]);
    end
    cf(ERB_MODE_SP, 4'h4, 4'h5, 4'h5, 1'b0);
    d = 36'($urandom);
    e = mem[a];
    mem[a] = d;
    erb_user_inst.op(pt(1'b1, 1'b1, F, a, d), nop, 2'b00);
    chk(q_a, e);
    y = a + 8'h01;
    mem[y] = ~d & 36'h0_FFFF_FFFF;
    erb_user_inst.op(pt(1'b1, 1'b0, F, y, mem[y]), nop, 2'b00);
    chk(q_a, e);
    erb_user_inst.op(pt(1'b0, 1'b1, F, a, e), nop, 2'b00);
    chk(q_a, mem[a]);
    cf(ERB_MODE_SP, 4'h1, 4'h5, 4'h5, 1'b0);
    erb_user_inst.op(pt(1'b0, 1'b1, F, y, d), nop, 2'b00);
    chk(q_a, mem[a]);
    @(posedge pclk);
    #1;
    chk(q_a, mem[y]);
    @(posedge pclk);
    #1;
    erb_user_inst.clr(1'b0);
    chk(q_a, 36'h0);
    erb_user_inst.unclr();
    cf(ERB_MODE_SP, 4'h0, 4'h5, 4'h5, 1'b0);
    erb_user_inst.op(pt(1'b0, 1'b1, F, y, d), nop, 2'b00);
    erb_user_inst.clr(1'b0);
    chk(q_a, 36'h0);
    erb_user_inst.unclr();
    chk(q_a, 36'h0);
    erb_user_inst.set_ce(1'b0);
    erb_user_inst.op(pt(1'b1, 1'b1, F, y, 36'h0), nop, 2'b00);
    chk(q_a, 36'h0);
    erb_user_inst.set_ce(1'b1);
    erb_user_inst.op(pt(1'b0, 1'b1, F, y, d), nop, 2'b00);
    chk(q_a, mem[y]);
    cf(ERB_MODE_ROM, 4'h0, 4'h5, 4'h5, 1'b0);
    erb_user_inst.op(pt(1'b1, 1'b1, F, y, d), nop, 2'b00);
    chk(q_a, mem[y]);
    $display("single port test finished");
    cf(ERB_MODE_SDP, 4'h0, 4'h8, 4'h4, 1'b1);
    cf(ERB_MODE_SDP, 4'h0, 4'h5, 4'h0, 1'b0);
    cf(ERB_MODE_SDP, 4'h8, 4'h8, 4'h8, 1'b0);
    a = 8'($urandom);
    y = a ^ 8'h01;
    for (int i = 0; i < 3; i++) begin
      d = {4'($urandom), 32'($urandom)};
      e = (i == 2) ? ERB_DC_FILL : mem[i == 0 ? y : a];
      if (i == 2) cf(ERB_MODE_SDP, 4'h0, 4'h8, 4'h8, 1'b0);
      erb_user_inst.op(pt(1'b1, 1'b0, F, a, d),
        pt(1'b0, 1'b1, F, i == 0 ? y : a, 36'h0), 2'b00);
      chk(q_b, e);
      mem[a] = d;
    end
    erb_user_inst.op(nop, pt(1'b0, 1'b1, F, a, 36'h0), 2'b00);
    chk(q_b, mem[a]);
    erb_user_inst.clr(1'b1);
    chk(q_b, 36'h0);
    erb_user_inst.unclr();
    $display("simple dual port test finished");
    cf(ERB_MODE_TDP, 4'h0, 4'h5, 4'h5, 1'b1);
    cf(ERB_MODE_TDP, 4'h0, 4'h4, 4'h6, 1'b1);
    cf(ERB_MODE_TDP, 4'h0, 4'h6, 4'h7, 1'b0);
    cf(ERB_MODE_TDP, 4'h8, 4'h4, 4'h4, 1'b0);
    d = 36'($urandom);
    erb_user_inst.op(pt(1'b1, 1'b0, F, a, d),
      pt(1'b1, 1'b0, F, y, ~d), 2'b00);
    mem[a] = d;
    mem[y] = ~d;
    erb_user_inst.op(pt(1'b0, 1'b1, F, a, 36'h0),
      pt(1'b0, 1'b1, F, y, 36'h0), 2'b00);
    chk(q_a, mem[a] & M16);
    chk(q_b, mem[y] & M16);
    erb_user_inst.op(pt(1'b1, 1'b0, F, a, ~d),
      pt(1'b0, 1'b1, F, a, 36'h0), 2'b00);
    chk(q_b, d & M16);
    erb_user_inst.op(pt(1'b1, 1'b0, F, a, d),
      pt(1'b1, 1'b0, F, a, ~d), 2'b01);
    erb_user_inst.op(pt(1'b0, 1'b1, F, a, 36'h0), nop, 2'b00);
    chk(q_a, M16);
    $display("true dual port test finished");
    cf(ERB_MODE_FIFO, 4'h0, 4'h8, 4'h8, 1'b0);
    for (int i = 0; i < 3; i++) begin
      d = {4'($urandom), 32'($urandom)};
      fq.push_back(d);
      erb_user_inst.op(pt(1'b1, 1'b0, F, 8'h00, d), nop, 2'b10);
    end
    chk(36'(fifo_empty), 36'h0);
    apb(1'b0, ERB_STAT_OFS, 32'h0);
    chk(36'(rdv[11:3]), 36'h3);
    for (int i = 0; i < 3; i++) begin
      erb_user_inst.op(nop, pt(1'b0, 1'b1, F, 8'h00, 36'h0), 2'b10);
      chk(q_b, fq.pop_front());
    end
    chk(36'(fifo_empty), 36'h1);
    for (int i = 0; i < 255; i++) begin
      erb_user_inst.op(pt(1'b1, 1'b0, F, 8'h00, d), nop, 2'b10);
    end
    chk(36'(fifo_full), 36'h0);
    erb_user_inst.op(pt(1'b1, 1'b0, F, 8'h00, d), nop, 2'b10);
    chk(36'(fifo_full), 36'h1);
    $display("fifo test finished");
    apb(1'b1, ERB_SRCFG_OFS, 32'h0001_0064);
    cf(ERB_MODE_SR, 4'h0, 4'h8, 4'h8, 1'b1);
    apb(1'b1, ERB_SRCFG_OFS, 32'h0001_0052);
    cf(ERB_MODE_SR, 4'h0, 4'h8, 4'h8, 1'b0);
    for (int i = 0; i < 3; i++) begin
      fq.push_back(36'($urandom) & 36'h0_0003_FFFF);
      erb_user_inst.op(pt(1'b1, 1'b0, F, 8'h00, fq[i]), nop, 2'b00);
    end
    chk(q_b, fq[0]);
    chk(q_a, {fq[0][17:0], fq[1][17:0]});
    $display("shift register test finished");
    report_and_stop();
  end
endmodule

`default_nettype wire
